// ===== rtl/kms_pkg.sv
// Package for the keypad matrix scanner: sizes, timing and states
package kms_pkg;
  localparam int ROWS = 5;
  localparam int COLS = 7;
  localparam int CLK_MHZ = 125;
  localparam int DEBOUNCE_MS = 25;
  // 25 ms at 125 MHz, well above 4096 cycles, so the top takes a parameter
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_MHZ * 1000;
  // Drive-state count after which a driven column is sampled, one cycle later
  localparam int SETTLE_CYC = 2;
  localparam logic [COLS-1:0] COLS_LOW = 7'h00;
  localparam logic [COLS-1:0] COLS_HIGH = 7'h7F;
  localparam logic [ROWS-1:0] ROWS_IDLE = 5'h1F;
  localparam logic [2:0] COL_LAST = 3'h6;
  typedef enum logic [2:0] {
    KMS_IDLE, KMS_WAIT, KMS_ROWS, KMS_COLS_HI, KMS_DRIVE, KMS_SAMPLE
  } kms_state_t;
endpackage

// ===== rtl/kms_scanner.sv
// Keypad matrix scanner: detect, debounce and locate one key
`timescale 1ns/10ps
module kms_scanner
#(
  parameter int DEBOUNCE_CYCLES = kms_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  // Matrix pins
  input  wire logic [kms_pkg::ROWS-1:0]  row_in,
  output logic      [kms_pkg::COLS-1:0]  col_out,
  output logic      [kms_pkg::COLS-1:0]  col_oe,
  // Processor side
  output logic                           key_irq,
  output logic                           key_valid,
  output logic      [2:0]                key_row,
  output logic      [2:0]                key_col
);
  import kms_pkg::*;

  // Row pins are asynchronous: two-stage synchroniser
  logic [ROWS-1:0] row_meta_reg;
  logic [ROWS-1:0] row_sync_reg;

  // Sequencer
  kms_state_t      state_reg;
  kms_state_t      state_next;
  logic [31:0]     cnt_reg;
  logic [31:0]     cnt_next;

  // Search bookkeeping
  logic [ROWS-1:0] row_hit_reg;
  logic [ROWS-1:0] row_hit_next;
  logic [2:0]      col_idx_reg;
  logic [2:0]      col_idx_next;
  logic [COLS-1:0] col_reg;
  logic [COLS-1:0] col_next;

  // Report
  logic            irq_reg;
  logic            irq_next;
  logic            valid_reg;
  logic            valid_next;
  logic [2:0]      key_row_reg;
  logic [2:0]      key_row_next;
  logic [2:0]      key_col_reg;
  logic [2:0]      key_col_next;

  // Lowest-index low row wins when several keys share a column
  function automatic logic [2:0] low_row(input logic [ROWS-1:0] r);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = ROWS - 1; i >= 0; i--) begin
      if (!r[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // Column pattern with only the selected column low
  function automatic logic [COLS-1:0] col_drive(input logic [2:0] idx);
    return ~(COLS'(1) << idx);
  endfunction

  // State decodes
  wire in_idle     = (state_reg == KMS_IDLE);
  wire in_rows     = (state_reg == KMS_ROWS);
  wire in_cols_hi  = (state_reg == KMS_COLS_HI);
  wire in_drive    = (state_reg == KMS_DRIVE);
  wire in_sample   = (state_reg == KMS_SAMPLE);

  // Row and counter decodes
  wire any_low     = (row_sync_reg != ROWS_IDLE);
  wire wait_done   = (cnt_reg == 32'(DEBOUNCE_CYCLES - 1));
  // Extra cycles per column let the pin settle and pass the synchroniser
  wire settle_done = (cnt_reg == 32'(SETTLE_CYC));
  wire pick_row    = |(~row_sync_reg & row_hit_reg);
  wire last_col    = (col_idx_reg == COL_LAST);
  wire hit_now     = in_sample && pick_row;
  wire search_end  = in_sample && (pick_row || last_col);
  wire stay        = (state_next == state_reg);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      row_meta_reg <= ROWS_IDLE;
      row_sync_reg <= ROWS_IDLE;
    end else begin
      row_meta_reg <= row_in;
      row_sync_reg <= row_meta_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      KMS_IDLE:    if (any_low) state_next = KMS_WAIT;
      KMS_WAIT:    if (wait_done) state_next = KMS_ROWS;
      KMS_ROWS:    state_next = any_low ? KMS_COLS_HI : KMS_IDLE;
      KMS_COLS_HI: state_next = KMS_DRIVE;
      KMS_DRIVE:   if (settle_done) state_next = KMS_SAMPLE;
      KMS_SAMPLE:  if (pick_row || last_col) state_next = KMS_IDLE;
                   else state_next = KMS_DRIVE;
    endcase
  end

  // Counter restarts on every state change
  assign cnt_next     = stay ? cnt_reg + 32'h0000_0001 : 32'h0000_0000;

  // A still-held key re-arms at once; no release wait is imposed
  assign irq_next     = in_idle && any_low;
  assign valid_next   = hit_now;

  // Rows low at the debounced re-read bound the search
  assign row_hit_next = in_rows ? ~row_sync_reg : row_hit_reg;

  assign col_idx_next = in_idle                    ? 3'h0 :
                        (in_sample && !search_end) ? col_idx_reg + 3'h1 :
                                                     col_idx_reg;

  assign col_next = (in_idle || search_end) ? COLS_LOW :
                    in_cols_hi ? COLS_HIGH :
                    in_drive   ? col_drive(col_idx_reg) :
                                 col_reg;

  assign key_row_next = hit_now ? low_row(row_sync_reg | ~row_hit_reg)
                                : key_row_reg;
  assign key_col_next = hit_now ? col_idx_reg : key_col_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= KMS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 32'h0000_0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      row_hit_reg <= ROWS_IDLE;
    end else begin
      row_hit_reg <= row_hit_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      col_idx_reg <= 3'h0;
    end else begin
      col_idx_reg <= col_idx_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      col_reg <= COLS_LOW;
    end else begin
      col_reg <= col_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= valid_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      key_row_reg <= 3'h0;
    end else begin
      key_row_reg <= key_row_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      key_col_reg <= 3'h0;
    end else begin
      key_col_reg <= key_col_next;
    end
  end

  // Only matrix rows are watched; the power key has no path here
  assign col_out   = col_reg;
  // Columns never float, so rows only see a defined level
  assign col_oe    = COLS_HIGH;
  assign key_irq   = irq_reg;
  assign key_valid = valid_reg;
  assign key_row   = key_row_reg;
  assign key_col   = key_col_reg;
endmodule

// ===== dv/kms_keys.sv
// Switch matrix model with row pull-ups
`timescale 1ns/10ps
module kms_keys (
  input  wire logic [6:0] col_out,
  input  wire logic [6:0] kp,
  output logic      [4:0] row_in
);
  // Pressed switch shorts its row to a low column, else pull-up wins
  assign row_in = 5'h1F ^ ({4'h0, kp[6] & ~col_out[kp[2:0]]} << kp[5:3]);
endmodule

// ===== dv/kms_checker.sv
// Port assertions for the keypad scanner
`timescale 1ns/10ps
module kms_checker (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic [4:0] row_in,
  input wire logic [6:0] col_out,
  input wire logic [6:0] col_oe,
  input wire logic       key_irq,
  input wire logic       key_valid,
  input wire logic [2:0] key_col
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_hi; col_out == 7'h7F ##1 col_out == 7'h7E; endsequence
  a_oe_on: assert property (col_oe == 7'h7F)
    else $error("oe");
  a_irq_row: assert property (key_irq |-> $past(row_in, 3) != 5'h1F)
    else $error("irq");
  a_irq_once: assert property (key_irq |=> !key_irq)
    else $error("irq2");
  a_wait_low: assert property (key_irq |=> (col_out == 0 && !key_valid)[*8])
    else $error("wait");
  a_high_first: assert property ($changed(col_out) && col_out == 7'h7F |-> s_hi)
    else $error("high");
  a_one_low: assert property (col_out inside {0, 7'h7F} || $onehot(~col_out))
    else $error("cols");
  a_valid_col: assert property (key_valid |-> ~$past(col_out) == 7'h01 << key_col)
    else $error("col");
  a_back_low: assert property ($rose(col_out == 7'h7F) |-> ##[1:40] col_out == 0)
    else $error("rearm");
endmodule
bind kms_scanner kms_checker chk (.clock, .rst_n, .row_in, .col_out, .col_oe,
  .key_irq, .key_valid, .key_col);

// ===== dv/keypad_matrix_scanner_test.sv
// Bench for the keypad matrix scanner
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module keypad_matrix_scanner_test;
  logic       clock = 0, rst_n = 0, key_irq, key_valid;
  logic [6:0] kp = 0, col_out, col_oe;
  logic [4:0] row_in;
  logic [2:0] key_row, key_col;
  int         errors = 0, total_checks = 0, n;
  always #4 clock = ~clock;
  // Short debounce keeps the run brief
  kms_scanner #(.DEBOUNCE_CYCLES(20)) dut (.clock, .rst_n, .row_in, .col_out,
    .col_oe, .key_irq, .key_valid, .key_row, .key_col);
  kms_keys keys (.col_out, .kp, .row_in);
  task automatic complete_run;
    $display("errors %0d total_checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_locate(input logic [5:0] rc);
    @(posedge clock) #1 kp = {1'b1, rc};
    for (n = 0; key_irq !== 1'b1 && n < 9; n++) @(posedge clock) #1;
    `CHK(n > 1, 1'b1)
    `CHK(key_irq, 1'b1)
    for (n = 0; key_valid !== 1'b1 && n < 99; n++) @(posedge clock) #1;
    `CHK(n >= 20, 1'b1)
    `CHK({key_row, key_col}, rc)
    `CHK(col_out, 7'h00)
    kp = 0;
    // Held key re-arms once; let that debounce pass back to idle
    repeat (40) @(posedge clock);
  endtask
  // Key let go before the second reading must not be reported
  task automatic t_bounce;
    @(posedge clock) #1 kp = 7'h4D;
    repeat (5) @(posedge clock) #1;
    kp = 0;
    for (n = 0; key_valid !== 1'b1 && n < 40; n++) @(posedge clock) #1;
    `CHK(n, 40)
    `CHK(col_out, 7'h00)
  endtask
  initial begin
    repeat (6) @(posedge clock);
    #1 rst_n = 1;
    `CHK(col_out, 7'h00)
    `CHK(col_oe, 7'h7F)
    t_locate(6'h00);
    t_locate(6'h26);
    t_locate(6'h13);
    t_bounce;
    complete_run;
  end
  initial begin
    #20000 errors++;
    complete_run;
  end
endmodule
